// ### crs_sequencer.sv
// reader-side command sequencer for a contactless transceiver
`include "crs_cfg.svh"

module crs_sequencer #(
  parameter int TICK_CYCLES = `CRS_TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire crs_pkg::crs_beat_t host_beat_in,
  input wire logic host_valid_in,
  output logic host_ready_out,
  output crs_pkg::crs_beat_t rsp_beat_out,
  output logic rsp_valid_out,
  output logic rf_search_out,
  output logic [7:0] rf_type_out,
  output logic [7:0] rf_mode_out,
  input wire logic rf_found_in,
  input wire crs_pkg::crs_card_t rf_card_in,
  output logic rf_halt_out,
  output logic [1:0] rf_halt_tgt_out,
  output crs_pkg::crs_beat_t rf_tx_beat_out,
  output logic rf_tx_valid_out,
  input wire crs_pkg::crs_beat_t rf_rx_beat_in,
  input wire logic rf_rx_valid_in,
  output logic rf_rx_ready_out,
  output logic [1:0] target_active_out,
  output logic busy_out
);
  import crs_pkg::*;

  crs_state_t state;
  logic [7:0] op, idx, list_type, cfg_item, retry_lim, retry_rem, exch_to, rounds, period, b1;
  logic [7:0] rsp_code, mode_q, send_byte;
  logic [3:0] time_slot_count, nmodes, mode_idx;
  logic [1:0] want, nfound;
  logic bad_tgt, is_poll, card_fmt, relay, pw_first, tmr_load, accept, tdone, polled;
  logic found_done, retry_ok, mode_we;
  logic [4:0] pos, len, k;
  logic [23:0] tmr, tmr_val, act_ticks;
  logic [15:0] presc;
  logic tick;
  logic [55:0] recv;
  crs_card_t card [2];

  // ************************************************************
  // timebase and timeout counter
  // ************************************************************
  // 10 us ticks keep the long timeouts in a narrow counter
  assign tick = (presc == 16'(TICK_CYCLES - 1));
  assign tdone = (tmr == 24'h0) && !tmr_load;
  assign act_ticks = 24'(`CRS_ACT_BASE_TICKS + (int'(time_slot_count) + 1) * `CRS_ACT_SLOT_TICKS);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc <= 16'h0000;
    end else begin
      presc <= tick ? 16'h0000 : presc + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmr <= 24'h000000;
    end else if (tmr_load) begin
      tmr <= tmr_val;
    end else if (tick && (tmr != 24'h0)) begin
      tmr <= tmr - 24'h000001;
    end
  end

  // ************************************************************
  // polling mode store
  // ************************************************************
  // at most fifteen modes kept
  assign mode_we = accept && (state == S_IDLE) && (op == `CRS_OP_POLL) && (idx >= 8'h03)
    && (nmodes < `CRS_MAX_MODES);

  crs_byte_mem #(.DEPTH(15), .AW(4)) u_modes (
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .we_in(mode_we),
    .waddr_in(nmodes),
    .wdata_in(host_beat_in.data),
    .raddr_in(mode_idx),
    .rdata_out(mode_q)
  );

  // ************************************************************
  // decisions and answer bytes
  // ************************************************************
  assign accept = host_valid_in && host_ready_out;
  // polled card type stops after one card
  assign polled = (mode_q == `CRS_MODE_POLL212) || (mode_q == `CRS_MODE_POLL424);
  // other poll types keep going until a second target
  assign found_done = is_poll ? (nfound == 2'd1 || polled) : ((nfound + 2'd1) >= want);
  // retry only while the limit exceeds one
  assign retry_ok = (retry_rem == `CRS_FOREVER) || (retry_rem > 8'h01);
  assign len = card_fmt ? 5'(2 + 7 * int'(nfound)) : ((op == `CRS_OP_JUMP) ? 5'd3 : 5'd2);

  always_comb begin
    k = (pos >= 5'd9) ? pos - 5'd9 : pos - 5'd2;
    recv = (pos >= 5'd9) ? {8'h02, card[1]} : {8'h01, card[0]};
    if (pos == 5'd0) begin
      send_byte = rsp_code;
    end else if (pos == 5'd1) begin
      send_byte = b1;
    end else if (!card_fmt) begin
      send_byte = 8'h01;
    end else begin
      send_byte = 8'(recv >> (8 * (6 - int'(k))));
    end
  end

  // ************************************************************
  // command state machine
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= S_IDLE;
      {op, idx, list_type, cfg_item, rounds, period, b1, rsp_code} <= 64'h0;
      retry_lim <= `CRS_RETRY_RST;
      retry_rem <= `CRS_RETRY_RST;
      exch_to <= `CRS_EXCH_TO_RST;
      {time_slot_count, nmodes, mode_idx} <= 12'h000;
      {want, nfound, target_active_out, rf_halt_tgt_out} <= 8'h00;
      {bad_tgt, is_poll, card_fmt, relay, pw_first, tmr_load} <= 6'h00;
      {rf_search_out, rf_halt_out, rsp_valid_out, rf_tx_valid_out, rf_rx_ready_out} <= 5'h00;
      host_ready_out <= 1'b1;
      {rf_type_out, rf_mode_out} <= 16'h0000;
      rsp_beat_out <= '0;
      rf_tx_beat_out <= '0;
      tmr_val <= 24'h000000;
      pos <= 5'd0;
      card[0] <= '0;
      card[1] <= '0;
    end else begin
      tmr_load <= 1'b0;
      rf_search_out <= 1'b0;
      rf_halt_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rf_tx_valid_out <= 1'b0;
      case (state)
        S_IDLE: begin
          if (accept) begin
            idx <= (idx == 8'hFF) ? idx : idx + 8'h01;
            if (idx == 8'h00) begin
              op <= host_beat_in.data;
              {bad_tgt, time_slot_count, nmodes, list_type} <= 17'h0;
              want <= 2'd1;
            end else if (op == `CRS_OP_LIST) begin
              if (idx == 8'h01) want <= (host_beat_in.data > 8'h01) ? 2'd2 : 2'd1;
              if (idx == 8'h02) list_type <= host_beat_in.data;
              if (idx >= 8'h03) time_slot_count <= host_beat_in.data[3:0];
            end else if (op == `CRS_OP_EXCH) begin
              if (idx == 8'h01) begin
                bad_tgt <= (host_beat_in.data != {6'h00, target_active_out})
                  || (target_active_out == 2'd0);
              end else if (!bad_tgt) begin
                // payload only, framing added by the transport below
                rf_tx_valid_out <= 1'b1;
                rf_tx_beat_out <= host_beat_in;
              end
            end else if (op == `CRS_OP_CFG) begin
              if (idx == 8'h01) cfg_item <= host_beat_in.data;
              if (idx == 8'h02 && cfg_item == `CRS_ITEM_RETRY) retry_lim <= host_beat_in.data;
              if (idx == 8'h02 && cfg_item == `CRS_ITEM_TIMEOUT) exch_to <= host_beat_in.data;
            end else if (op == `CRS_OP_POLL) begin
              // count and period in 150 ms units
              if (idx == 8'h01) rounds <= host_beat_in.data;
              if (idx == 8'h02) period <= host_beat_in.data;
              if (mode_we) nmodes <= nmodes + 4'h1;
            end else if (op == `CRS_OP_JUMP) begin
              // mode byte is the only difference
              if (idx == 8'h01) rf_mode_out <= host_beat_in.data;
            end
            if (host_beat_in.last) begin
              idx <= 8'h00;
              host_ready_out <= 1'b0;
              state <= S_DISP;
            end
          end
        end
        S_DISP: begin
          nfound <= 2'd0;
          relay <= 1'b0;
          retry_rem <= retry_lim;
          rsp_code <= op + 8'h01;
          b1 <= `CRS_ST_OK;
          card_fmt <= 1'b0;
          is_poll <= (op == `CRS_OP_POLL);
          pos <= 5'd0;
          state <= S_SEND;
          if (op == `CRS_OP_LIST || op == `CRS_OP_JUMP) begin
            target_active_out <= 2'd0;
            rf_search_out <= 1'b1;
            rf_type_out <= (op == `CRS_OP_LIST) ? list_type : op;
            tmr_load <= 1'b1;
            tmr_val <= act_ticks;
            state <= S_SEARCH;
          end else if (op == `CRS_OP_EXCH) begin
            b1 <= `CRS_ST_FAIL;
            if (!bad_tgt) begin
              tmr_load <= 1'b1;
              tmr_val <= 24'(int'(exch_to) * `CRS_EXCH_UNIT_TICKS);
              state <= S_XWAIT;
            end
          end else if (op == `CRS_OP_POLL) begin
            target_active_out <= 2'd0;
            card_fmt <= 1'b1;
            b1 <= 8'h00;
            mode_idx <= 4'h0;
            pw_first <= 1'b1;
            tmr_load <= 1'b1;
            tmr_val <= 24'h0;
            if (nmodes != 4'h0) state <= S_PWAIT;
          end else if (op == `CRS_OP_REL) begin
            // nothing sent over RF, status always 00
            target_active_out <= 2'd0;
          end else if (op != `CRS_OP_DESEL && op != `CRS_OP_CFG) begin
            b1 <= `CRS_ST_FAIL;
          end
        end
        S_PWAIT: begin
          // first cycle lets the mode store deliver its byte
          pw_first <= 1'b0;
          if (!pw_first && tdone) begin
            rf_search_out <= 1'b1;
            rf_type_out <= mode_q;
            tmr_load <= 1'b1;
            tmr_val <= act_ticks;
            state <= S_SEARCH;
          end
        end
        S_SEARCH: begin
          if (rf_found_in) begin
            card[nfound[0]] <= rf_card_in;
            nfound <= nfound + 2'd1;
            // found target left ready for exchange
            target_active_out <= nfound + 2'd1;
            if (is_poll && nfound == 2'd1) begin
              rf_halt_out <= 1'b1;
              rf_halt_tgt_out <= 2'd1;
            end
          end
          if (rf_found_in && found_done) begin
            card_fmt <= (op != `CRS_OP_JUMP);
            b1 <= (op == `CRS_OP_JUMP) ? `CRS_ST_OK : {6'h00, nfound + 2'd1};
            pos <= 5'd0;
            state <= S_SEND;
          end else if (rf_found_in || tdone) begin
            if (is_poll) begin
              pw_first <= 1'b1;
              tmr_load <= 1'b1;
              tmr_val <= 24'h0;
              if (mode_idx + 4'h1 < nmodes) begin
                mode_idx <= mode_idx + 4'h1;
                state <= S_PWAIT;
              end else if (nfound == 2'd0 && !rf_found_in
                  && (rounds == `CRS_FOREVER || rounds > 8'h01)) begin
                if (rounds != `CRS_FOREVER) rounds <= rounds - 8'h01;
                mode_idx <= 4'h0;
                tmr_val <= 24'(int'(period) * `CRS_POLL_UNIT_TICKS);
                state <= S_PWAIT;
              end else begin
                b1 <= {6'h00, nfound + {1'b0, rf_found_in}};
                pos <= 5'd0;
                state <= S_SEND;
              end
            end else if (op == `CRS_OP_JUMP) begin
              b1 <= `CRS_ST_FAIL;
              pos <= 5'd0;
              state <= S_SEND;
            end else if (rf_found_in || retry_ok) begin
              if (!rf_found_in && retry_rem != `CRS_FOREVER) retry_rem <= retry_rem - 8'h01;
              rf_search_out <= 1'b1;
              tmr_load <= 1'b1;
              tmr_val <= act_ticks;
            end else begin
              // answer with what was found, maybe zero
              card_fmt <= 1'b1;
              b1 <= {6'h00, nfound};
              pos <= 5'd0;
              state <= S_SEND;
            end
          end
        end
        S_XWAIT: begin
          // status 00 once the card answers, failure on timeout
          if (rf_rx_valid_in || tdone) begin
            b1 <= rf_rx_valid_in ? `CRS_ST_OK : `CRS_ST_FAIL;
            relay <= rf_rx_valid_in;
            pos <= 5'd0;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          rsp_valid_out <= 1'b1;
          rsp_beat_out.data <= send_byte;
          rsp_beat_out.last <= (pos == len - 5'd1) && !relay;
          pos <= pos + 5'd1;
          if (pos == len - 5'd1) begin
            rf_rx_ready_out <= relay;
            host_ready_out <= !relay;
            state <= relay ? S_XRELAY : S_IDLE;
          end
        end
        S_XRELAY: begin
          if (rf_rx_valid_in && rf_rx_ready_out) begin
            rsp_valid_out <= 1'b1;
            rsp_beat_out <= rf_rx_beat_in;
            if (rf_rx_beat_in.last) begin
              rf_rx_ready_out <= 1'b0;
              host_ready_out <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state != S_IDLE);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  a_resp_code_first: assert property (state == S_SEND && pos == 5'd0
    |=> rsp_valid_out && rsp_beat_out.data == op + 8'h01) else $error("bad answer code");
  a_desel_no_rf: assert property (state == S_DISP && (op == 8'h44 || op == 8'h52)
    |-> ##2 (rsp_valid_out && !rf_search_out) ##1 (rsp_beat_out.data == 8'h00
    && rsp_beat_out.last && !rf_search_out)) else $error("deactivation not plain ok");
  a_act_window: assert property (state == S_SEARCH && tmr_load
    |=> tmr == 24'(242 + (int'(time_slot_count) + 1) * 121)) else $error("activation window wrong");
  a_retry_stop: assert property (state == S_SEARCH && tdone && !rf_found_in
    && op == 8'h4A && retry_rem == 8'h01 |-> ##2 rsp_valid_out
    && rsp_beat_out.data == 8'h4B) else $error("retry limit not honoured");
  a_retry_forever: assert property (state == S_SEARCH && tdone && !rf_found_in
    && op == 8'h4A && retry_rem == 8'hFF |=> rf_search_out && retry_rem == 8'hFF)
    else $error("endless retry stopped");
  a_exch_window: assert property (state == S_DISP && op == 8'h40 && !bad_tgt
    |=> ##1 tmr == 24'(int'(exch_to) * 40)) else $error("exchange window wrong");
  a_list_max_two: assert property (want <= 2'd2 && nfound <= 2'd2)
    else $error("more than two cards");
  a_list_answer: assert property (state == S_SEND && pos == 5'd1 && op == 8'h4A
    |=> rsp_beat_out.data == {6'h00, nfound}) else $error("list count wrong");
  a_exch_status: assert property (state == S_XWAIT && rf_rx_valid_in
    |-> ##2 rsp_beat_out.data == 8'h41 ##1 rsp_beat_out.data == 8'h00
    && !rsp_beat_out.last) else $error("exchange header wrong");
  a_poll_polled_one: assert property (state == S_SEARCH && is_poll && rf_found_in
    && polled |=> state == S_SEND) else $error("polled type kept searching");
  a_halt_first: assert property (state == S_SEARCH && is_poll && rf_found_in
    && nfound == 2'd1 |=> rf_halt_out && rf_halt_tgt_out == 2'd1
    && target_active_out == 2'd2) else $error("first target not halted");
  a_poll_modes: assert property (accept && state == S_IDLE && op == 8'h5E
    && idx >= 8'h03 && nmodes == 4'd15 |=> nmodes == 4'd15) else $error("too many modes");
  a_poll_ready: assert property (state == S_SEND && is_poll && b1 != 8'h00
    |-> target_active_out != 2'd0) else $error("polled target not active");
  a_tx_payload: assert property (rf_tx_valid_out
    |-> $past(host_valid_in) && rf_tx_beat_out == $past(host_beat_in))
    else $error("payload altered");

  c_list_found: cover property (state == S_SEARCH && rf_found_in && op == 8'h4A);
  c_exch_relay: cover property (state == S_XRELAY && rf_rx_valid_in && rf_rx_beat_in.last);
  c_poll_halt: cover property (rf_halt_out);
endmodule

// ### crs_cfg.svh
// constants for the contactless reader command sequencer
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ************************************************************
// timing
// ************************************************************
`define CRS_CLK_PERIOD_NS 10
`define CRS_TICK_NS 10000
`define CRS_TICK_CYCLES (`CRS_TICK_NS / `CRS_CLK_PERIOD_NS)
`define CRS_ACT_BASE_US 2420
`define CRS_ACT_SLOT_US 1210
`define CRS_EXCH_UNIT_US 400
`define CRS_POLL_UNIT_US 150000
`define CRS_ACT_BASE_TICKS (`CRS_ACT_BASE_US * 1000 / `CRS_TICK_NS)
`define CRS_ACT_SLOT_TICKS (`CRS_ACT_SLOT_US * 1000 / `CRS_TICK_NS)
`define CRS_EXCH_UNIT_TICKS (`CRS_EXCH_UNIT_US * 1000 / `CRS_TICK_NS)
`define CRS_POLL_UNIT_TICKS (`CRS_POLL_UNIT_US * 1000 / `CRS_TICK_NS)

// ************************************************************
// reset values and limits
// ************************************************************
`define CRS_EXCH_TO_RST 8'h80
`define CRS_RETRY_RST 8'hFF
`define CRS_FOREVER 8'hFF
`define CRS_MAX_MODES 4'hF

// ************************************************************
// command codes, items, status, mode bytes
// ************************************************************
`define CRS_OP_EXCH 8'h40
`define CRS_OP_DESEL 8'h44
`define CRS_OP_LIST 8'h4A
`define CRS_OP_REL 8'h52
`define CRS_OP_JUMP 8'h56
`define CRS_OP_CFG 8'h3A
`define CRS_OP_POLL 8'h5E
`define CRS_ITEM_TIMEOUT 8'h02
`define CRS_ITEM_RETRY 8'h05
`define CRS_ST_OK 8'h00
`define CRS_ST_FAIL 8'h01
`define CRS_MODE_POLL212 8'h11
`define CRS_MODE_POLL424 8'h12

`endif

// ### crs_pkg.sv
// types shared by the sequencer files
package crs_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DISP = 3'b001,
    S_SEARCH = 3'b010,
    S_PWAIT = 3'b011,
    S_XWAIT = 3'b100,
    S_XRELAY = 3'b101,
    S_SEND = 3'b110
  } crs_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } crs_beat_t;

  typedef struct packed {
    logic [15:0] atqa;
    logic [31:0] uid;
  } crs_card_t;
endpackage

// ### crs_byte_mem.sv
// small byte memory with registered read data
module crs_byte_mem #(
  parameter int DEPTH = 15,
  parameter int AW = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in && (int'(waddr_in) < DEPTH)) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule

// ### crs_rf_model.sv
// rf-side card model for the sequencer bench
module crs_rf_model (
  input wire logic core_clk_in,
  input wire logic rf_search_in,
  input wire crs_pkg::crs_beat_t rf_tx_beat_in,
  input wire logic rf_tx_valid_in,
  input wire logic rf_rx_ready_in,
  output logic rf_found_out,
  output crs_pkg::crs_card_t rf_card_out,
  output crs_pkg::crs_beat_t rf_rx_beat_out,
  output logic rf_rx_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import crs_pkg::*;
  logic present = 1'b0;
  logic answer = 1'b0;
  int find_dly = 3;
  crs_card_t card = '0;
  logic [7:0] rx_q[$];
  initial begin
    rf_found_out = 0;
    rf_card_out = '0;
    rf_rx_valid_out = 0;
    rf_rx_beat_out = '0;
  end
  always @(posedge core_clk_in) begin
    if (rf_search_in && present) begin
      repeat (find_dly) @(posedge core_clk_in);
      #1 rf_found_out = 1;
      rf_card_out = card;
      @(posedge core_clk_in);
      #1 rf_found_out = 0;
      rf_card_out = ~card;
    end
  end
  always @(posedge core_clk_in) begin
    if (rf_tx_valid_in && rf_tx_beat_in.last && answer) begin
      repeat (find_dly) @(posedge core_clk_in);
      foreach (rx_q[i]) begin
        #1 rf_rx_valid_out = 1;
        rf_rx_beat_out.data = rx_q[i];
        rf_rx_beat_out.last = (i == rx_q.size() - 1);
        // ready is registered, so its mid-cycle level is what the edge samples
        do @(negedge core_clk_in); while (!rf_rx_ready_in);
        @(posedge core_clk_in);
      end
      #1 rf_rx_valid_out = 0;
      rf_rx_beat_out = ~rf_rx_beat_out;
    end
  end
endmodule

// ### crs_sequencer_tb.sv
// self-checking bench for the reader command sequencer
module crs_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import crs_pkg::*;
  localparam int TICK = 2;
  `define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
  typedef logic [7:0] crs_bq_t[$];
  logic core_clk_in, resetn_in, host_valid_in, host_ready_out, rsp_valid_out, rf_search_out;
  logic rf_found_in, rf_halt_out, rf_tx_valid_out, rf_rx_valid_in, rf_rx_ready_out, busy_out;
  logic [7:0] rf_type_out, rf_mode_out, c, v;
  logic [1:0] rf_halt_tgt_out, target_active_out;
  crs_beat_t host_beat_in, rsp_beat_out, rf_tx_beat_out, rf_rx_beat_in;
  crs_card_t rf_card_in;
  int fail_count = 0;
  int check_count = 0;
  int seed = 32'h41f8;
  int searches = 0;
  int w;
  int halts = 0;
  crs_bq_t e2;
  logic [7:0] rsp_q[$], tx_q[$];
  logic [7:0] tag_ops[6] = '{8'h00, 8'h01, 8'h1A, 8'h1C, 8'h53, 8'h55};
  crs_sequencer #(.TICK_CYCLES(TICK)) i_dut (.core_clk_in, .resetn_in, .host_beat_in,
    .host_valid_in, .host_ready_out, .rsp_beat_out, .rsp_valid_out, .rf_search_out,
    .rf_type_out, .rf_mode_out, .rf_found_in, .rf_card_in, .rf_halt_out, .rf_halt_tgt_out,
    .rf_tx_beat_out, .rf_tx_valid_out, .rf_rx_beat_in, .rf_rx_valid_in, .rf_rx_ready_out,
    .target_active_out, .busy_out);
  crs_rf_model i_rf (.core_clk_in, .rf_search_in(rf_search_out), .rf_tx_beat_in(rf_tx_beat_out),
    .rf_tx_valid_in(rf_tx_valid_out), .rf_rx_ready_in(rf_rx_ready_out), .rf_found_out(rf_found_in),
    .rf_card_out(rf_card_in), .rf_rx_beat_out(rf_rx_beat_in), .rf_rx_valid_out(rf_rx_valid_in));
  initial begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    if (rsp_valid_out) rsp_q.push_back(rsp_beat_out.data);
    if (rf_tx_valid_out) tx_q.push_back(rf_tx_beat_out.data);
    if (rf_search_out) searches++;
    if (rf_halt_out) halts++;
  end
  // ************************************************************
  // host side helpers
  // ************************************************************
  function automatic crs_bq_t list_rsp(input logic [7:0] code, input crs_card_t k);
    return '{code, 8'h01, 8'h01, k.atqa[15:8], k.atqa[7:0], k.uid[31:24], k.uid[23:16],
      k.uid[15:8], k.uid[7:0]};
  endfunction
  task automatic send(input crs_bq_t b);
    foreach (b[i]) begin
      #1 host_valid_in = 1;
      host_beat_in.data = b[i];
      host_beat_in.last = (i == b.size() - 1);
      do @(negedge core_clk_in); while (!host_ready_out);
      @(posedge core_clk_in);
    end
    #1 host_valid_in = 0;
    host_beat_in = ~host_beat_in;
  endtask
  task automatic expect_rsp(input crs_bq_t e, input int lim);
    int n;
    n = 0;
    while (rsp_q.size() < e.size() && n < lim) begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (4) @(posedge core_clk_in);
    `CHK("response length", e.size(), rsp_q.size())
    foreach (e[i]) `CHK("response byte", e[i], rsp_q[i])
    rsp_q = {};
  endtask
  task automatic complete_run();
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk_in);
    fail_count++;
    complete_run();
  end
  initial begin
    resetn_in = 0;
    host_valid_in = 0;
    host_beat_in = '0;
    repeat (16) @(posedge core_clk_in);
    #1 resetn_in = 1;
    @(posedge core_clk_in);
    send('{8'h44, 8'h01});
    expect_rsp('{8'h45, 8'h00}, 20);
    c = 8'h60 + 8'($random(seed) & 15);
    send('{c, 8'h01});
    expect_rsp('{c + 8'h01, 8'h01}, 20);
    `CHK("rf activity", 0, searches + tx_q.size())
    i_rf.card = {16'($random(seed)), 32'($random(seed))};
    send('{8'h4A, 8'h01, 8'h04});
    repeat (2500) @(posedge core_clk_in);
    `CHK("search count", 1'b1, searches >= 3)
    `CHK("busy while searching", 1'b1, busy_out)
    i_rf.present = 1;
    expect_rsp(list_rsp(8'h4B, i_rf.card), 2000);
    i_rf.answer = 1;
    foreach (tag_ops[i]) begin
      v = 8'($random(seed));
      i_rf.find_dly = 1 + ($random(seed) & 7);
      i_rf.rx_q = '{8'($random(seed)), v, tag_ops[i]};
      tx_q = {};
      send('{8'h40, 8'h01, tag_ops[i], v});
      expect_rsp('{8'h41, 8'h00, i_rf.rx_q[0], v, tag_ops[i]}, 200);
      `CHK("rf payload", {tag_ops[i], v}, {tx_q[0], tx_q[1]})
    end
    send('{8'h40, 8'h02, 8'h01});
    expect_rsp('{8'h41, 8'h01}, 20);
    // silent card: default timeout first, then a short programmed one
    i_rf.answer = 0;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'(1 + ($random(seed) & 7)) : 8'h80;
      if (k) send('{8'h3A, 8'h02, v});
      if (k) expect_rsp('{8'h3B, 8'h00}, 20);
      send('{8'h40, 8'h01, 8'h00});
      repeat (v * 40 * TICK - 10) @(posedge core_clk_in);
      `CHK("early timeout", 0, rsp_q.size())
      repeat (30) @(posedge core_clk_in);
      `CHK("timeout code", 8'h41, rsp_q[0])
      `CHK("timeout status", 1'b1, rsp_q[1] != 8'h00)
      rsp_q = {};
    end
    send('{8'h52, 8'h01});
    expect_rsp('{8'h53, 8'h00}, 20);
    `CHK("active target", 2'h0, target_active_out)
    i_rf.present = 0;
    for (int n = 1; n <= 3; n++) begin
      w = (242 + (n + 1) * 121) * TICK;
      send('{8'h3A, 8'h05, 8'(n)});
      expect_rsp('{8'h3B, 8'h00}, 20);
      searches = 0;
      send('{8'h4A, 8'h01, 8'h04, 8'(n)});
      repeat (n * w - 10) @(posedge core_clk_in);
      `CHK("early answer", 0, rsp_q.size())
      expect_rsp('{8'h4B, 8'h00}, 20 + 5 * n);
      `CHK("search attempts", n, searches)
    end
    e2 = '{8'h5E, 8'h01, 8'h00};
    repeat (16) e2.push_back(8'h20);
    searches = 0;
    send(e2);
    expect_rsp('{8'h5F, 8'h00}, 12000);
    `CHK("poll searches", 15, searches)
    searches = 0;
    send('{8'h5E, 8'h03, 8'h00, 8'h20});
    expect_rsp('{8'h5F, 8'h00}, 3000);
    `CHK("poll rounds", 3, searches)
    i_rf.present = 1;
    i_rf.card = {16'($random(seed)), 32'($random(seed))};
    send('{8'h5E, 8'h01, 8'h01, 8'h11});
    expect_rsp(list_rsp(8'h5F, i_rf.card), 200);
    `CHK("poll mode", 8'h11, rf_type_out)
    i_rf.answer = 1;
    i_rf.rx_q = '{8'h5A};
    send('{8'h40, 8'h01, 8'h01});
    expect_rsp('{8'h41, 8'h00, 8'h5A}, 200);
    // jump activation, no parameter select after
    for (int m = 0; m < 2; m++) begin
      send('{8'h56, 8'(m)});
      expect_rsp('{8'h57, 8'h00, 8'h01}, 200);
      `CHK("peer type", 8'h56, rf_type_out)
      `CHK("peer mode", 8'(m), rf_mode_out)
    end
    e2 = list_rsp(8'h5F, i_rf.card);
    e2[1] = 8'h02;
    e2 = {e2, 8'h02, e2[3:8]};
    send('{8'h5E, 8'h01, 8'h00, 8'h20, 8'h10});
    expect_rsp(e2, 400);
    `CHK("halt pulses", 1, halts)
    `CHK("halted target", 2'h1, rf_halt_tgt_out)
    `CHK("latest target", 2'h2, target_active_out)
    complete_run();
  end
endmodule
